// ### logic/acs_pkg.sv
// Shared constants, register map and state types of the conversion sequencer.
// Assumes one 20 MHz clock; converter timing runs on source ticks.
package acs_pkg;

   localparam int          ACS_ADDR_W      = 4;
   localparam logic [3:0]  ACS_OFF_CTRL    = 4'h0;
   localparam logic [3:0]  ACS_OFF_STATUS  = 4'h4;
   localparam logic [3:0]  ACS_OFF_RESULT  = 4'h8;
   localparam logic [3:0]  ACS_OFF_PRESC   = 4'hC;
   localparam logic [1:0]  ACS_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  ACS_RESP_SLVERR = 2'h2;

   // Control register fields
   localparam int ACS_B_START   = 0;
   localparam int ACS_B_AUTO    = 1;
   localparam int ACS_B_SPEED   = 2;
   localparam int ACS_B_GAIN    = 4;
   localparam int ACS_B_AMP     = 5;
   localparam int ACS_B_CURSRC  = 6;
   localparam int ACS_B_CHAN    = 8;
   // Status register fields
   localparam int ACS_B_BUSY    = 0;
   localparam int ACS_B_PEND    = 1;
   localparam int ACS_B_RESULT  = 8;
   // Prescaler mirror fields
   localparam int ACS_B_FAST_CLOCK_MODE   = 0;
   localparam int ACS_B_CLOCK_SOURCE_SELECT    = 1;
   localparam int ACS_B_FS      = 2;
   localparam int ACS_B_PS      = 5;

   // Phase lengths in conversion clocks
   localparam logic [4:0] ACS_DELAY_CYC   = 5'h01;
   localparam logic [4:0] ACS_SAMPLE_CYC  = 5'h04;
   localparam logic [4:0] ACS_OFFSET_CYC  = 5'h06;
   localparam logic [4:0] ACS_CORRECT_CYC = 5'h05;
   localparam logic [4:0] ACS_CONVERT_CYC = 5'h09;
   localparam logic [4:0] ACS_STD_TOTAL   =
      5'(ACS_DELAY_CYC + ACS_SAMPLE_CYC + ACS_CONVERT_CYC);
   localparam logic [4:0] ACS_AZ_TOTAL    =
      5'(ACS_DELAY_CYC + ACS_OFFSET_CYC + ACS_CORRECT_CYC + ACS_CONVERT_CYC);

   // Timer clock divide factors towards a 1 us conversion cycle
   localparam logic [5:0] ACS_TDIV_BASE = 6'h02;
   localparam logic [5:0] ACS_TDIV_SRC  = 6'h04;
   localparam logic [5:0] ACS_TDIV_FAST = 6'h10;

   localparam logic [7:0] ACS_SAR_MSB   = 8'h80;
   localparam logic [5:0] ACS_ONE6      = 6'h01;

   typedef enum logic [2:0] {
      PH_IDLE, PH_DELAY, PH_OFFSET, PH_CORRECT, PH_SAMPLE, PH_CONVERT,
      PH_FINISH
   } acs_phase_t;

   typedef struct packed {
      acs_phase_t  phase;
      logic [4:0]  phCnt;
      logic        busy;
      logic        pend;
      logic [7:0]  result;
      logic [7:0]  sar;
      logic        autoSel;
      logic [1:0]  speed;
      logic        gain;
      logic        ampEn;
      logic        curEn;
      logic [2:0]  chan;
      logic        fast_clock_mode;
      logic        clock_source_select;
      logic [2:0]  fs;
      logic [2:0]  ps;
      logic        cAuto;
      logic [1:0]  cSpeed;
      logic        cGain;
      logic [2:0]  cChan;
      logic        strobeD;
      logic        awHave;
      logic        wHave;
      logic [3:0]  awAddr;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } acs_state_t;

endpackage

// ### logic/acs_sync2.sv
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module acs_sync2 import acs_pkg::*; (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic din,
   output logic      dout
);
   logic [1:0] sync_q;
   logic [1:0] sync_d;

   always_comb begin
      sync_d = {sync_q[0], din};
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_q <= 2'h0;
      end else begin
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q[1];
endmodule

// ### logic/acs_tick_divider.sv
// Divides a stream of one-cycle source ticks by a runtime ratio.
// Assumes ratio is at least one; restart realigns the count.
`timescale 1ns/1ps
module acs_tick_divider import acs_pkg::*; (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       srcTick,
   input  wire logic [5:0] ratio,
   input  wire logic       restart,
   output logic            outTick
);
   logic [5:0] count_q;
   logic [5:0] count_d;
   logic       wrap;

   assign wrap    = (count_q >= 6'(ratio - ACS_ONE6));
   assign outTick = srcTick && wrap && !restart;

   always_comb begin
      count_d = count_q;
      if (restart) begin
         count_d = 6'h00;
      end else if (srcTick) begin
         count_d = wrap ? 6'h00 : 6'(count_q + ACS_ONE6);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= 6'h00;
      end else begin
         count_q <= count_d;
      end
   end
endmodule

// ### logic/acs_sequencer.sv
// Conversion sequencer of an 8-bit successive-approximation converter.
// Assumes AXI4-Lite master on clk; ticks arrive on clk, comparator and
// timer strobe are asynchronous.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module acs_sequencer import acs_pkg::*; (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic [ACS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ACS_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  instructionClockTick,
   input  wire logic                  pwmTimerClockTick,
   input  wire logic                  timerConversionStrobe,
   input  wire logic                  comparatorHigh,
   output logic [2:0]                 muxChannel,
   output logic [7:0]                 sarTrial,
   output logic                       sampleHoldEnable,
   output logic                       offsetMeasureEnable,
   output logic                       offsetCorrectEnable,
   output logic                       convertEnable,
   output logic                       autozeroEnable,
   output logic                       errorAmpEnable,
   output logic                       currentSourceEnable,
   output logic                       conversionInProgress,
   output logic                       conversionPendingFlag,
   output logic [7:0]                 conversionResult
);
   acs_state_t st_q;
   acs_state_t st_d;
   logic       strobeS;
   logic       compS;
   logic       strobeRise;
   logic       swStart;
   logic       startConv;
   logic       setPend;
   logic       effAuto;
   logic [1:0] effSpeed;
   logic [5:0] timerRatio;
   logic [5:0] speedRatio;
   logic       timerTick;
   logic       srcTick;
   logic       convTick;
   logic       doWrite;
   logic [3:0] rdAddr;
   logic [3:0] wrAddr;
   logic [2:0] bitPos;

   acs_sync2 u_syncStrobe (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (timerConversionStrobe),
      .dout  (strobeS)
   );

   acs_sync2 u_syncComp (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (comparatorHigh),
      .dout  (compS)
   );

   // Timer ticks divided towards a 1 us cycle, prescale value ignored
   always_comb begin
      timerRatio = st_q.fast_clock_mode ? ACS_TDIV_FAST :
                   st_q.clock_source_select  ? ACS_TDIV_SRC  : ACS_TDIV_BASE;
      timerRatio = st_q.fs[0] ? 6'(timerRatio << 1) : timerRatio;
   end

   acs_tick_divider u_timerDiv (
      .clk     (clk),
      .rst_b   (rst_b),
      .srcTick (pwmTimerClockTick),
      .ratio   (timerRatio),
      .restart (startConv),
      .outTick (timerTick)
   );

   // Restarting on trigger keeps the cycle aligned with the strobe edge
   assign effAuto    = st_q.busy ? st_q.cAuto : st_q.autoSel;
   assign effSpeed   = st_q.busy ? st_q.cSpeed : st_q.speed;
   assign srcTick    = effAuto ? timerTick : instructionClockTick;
   assign speedRatio = 6'(ACS_ONE6 << effSpeed);

   acs_tick_divider u_speedDiv (
      .clk     (clk),
      .rst_b   (rst_b),
      .srcTick (srcTick),
      .ratio   (speedRatio),
      .restart (startConv),
      .outTick (convTick)
   );

   assign strobeRise = strobeS && !st_q.strobeD;
   assign doWrite    = st_q.awHave && st_q.wHave && !st_q.bvalid;
   assign wrAddr     = {st_q.awAddr[3:2], 2'h0};
   assign rdAddr     = {s_axi_araddr[3:2], 2'h0};
   assign swStart    = doWrite && wrAddr == ACS_OFF_CTRL && st_q.wStrb[0] &&
                       st_q.wData[ACS_B_START];
   // Busy triggers are lost on purpose
   assign startConv  = !st_q.busy &&
                       (st_q.autoSel ? strobeRise : swStart);
   assign setPend    = convTick && st_q.phase == PH_CONVERT &&
                       st_q.phCnt == 5'h00;
   assign bitPos     = 3'(st_q.phCnt - 5'h01);

   always_comb begin
      st_d = st_q;
      st_d.strobeD = strobeS;
      // Register bus
      if (s_axi_awvalid && s_axi_awready) begin
         st_d.awHave = 1'b1;
         st_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_d.wHave = 1'b1;
         st_d.wData = s_axi_wdata;
         st_d.wStrb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (doWrite) begin
         st_d.awHave = 1'b0;
         st_d.wHave  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = ACS_RESP_OKAY;
         case (wrAddr)
            ACS_OFF_CTRL: begin
               // Stored at once; the running conversion keeps its copy of auto, speed, gain and channel
               if (st_q.wStrb[0]) begin
                  st_d.autoSel = st_q.wData[ACS_B_AUTO];
                  st_d.speed   = st_q.wData[ACS_B_SPEED +: 2];
                  st_d.gain    = st_q.wData[ACS_B_GAIN];
                  st_d.ampEn   = st_q.wData[ACS_B_AMP];
                  st_d.curEn   = st_q.wData[ACS_B_CURSRC];
               end
               if (st_q.wStrb[1]) begin
                  st_d.chan = st_q.wData[ACS_B_CHAN +: 3];
               end
            end
            ACS_OFF_STATUS: begin
               if (st_q.wStrb[0] && st_q.wData[ACS_B_PEND]) begin
                  st_d.pend = 1'b0;
               end
            end
            ACS_OFF_RESULT: begin
            end
            ACS_OFF_PRESC: begin
               if (st_q.wStrb[0]) begin
                  st_d.fast_clock_mode = st_q.wData[ACS_B_FAST_CLOCK_MODE];
                  st_d.clock_source_select  = st_q.wData[ACS_B_CLOCK_SOURCE_SELECT];
                  st_d.fs    = st_q.wData[ACS_B_FS +: 3];
                  st_d.ps    = st_q.wData[ACS_B_PS +: 3];
               end
            end
            default: begin
               st_d.bresp = ACS_RESP_SLVERR;
            end
         endcase
      end
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_d.rvalid = 1'b1;
         st_d.rresp  = ACS_RESP_OKAY;
         case (rdAddr)
            ACS_OFF_CTRL: begin
               st_d.rdata = {21'h0, st_q.chan, 1'b0, st_q.curEn, st_q.ampEn,
                             st_q.gain, st_q.speed, st_q.autoSel, st_q.busy};
            end
            ACS_OFF_STATUS: begin
               st_d.rdata = {16'h0, st_q.result, 6'h0, st_q.pend, st_q.busy};
            end
            ACS_OFF_RESULT: begin
               st_d.rdata = {24'h0, st_q.result};
            end
            ACS_OFF_PRESC: begin
               st_d.rdata = {24'h0, st_q.ps, st_q.fs, st_q.clock_source_select, st_q.fast_clock_mode};
            end
            default: begin
               st_d.rdata = 32'h0;
               st_d.rresp = ACS_RESP_SLVERR;
            end
         endcase
      end
      // Conversion sequence
      if (startConv) begin
         // A starting write's speed, gain and channel fields already count for this run; auto keeps its old value
         st_d.busy   = 1'b1;
         st_d.cAuto  = st_q.autoSel;
         st_d.cSpeed = st_d.speed;
         st_d.cGain  = st_d.gain;
         st_d.cChan  = st_d.chan;
         st_d.phase  = PH_DELAY;
      end
      case (st_q.phase)
         PH_IDLE: begin
         end
         PH_DELAY: begin
            if (convTick && st_q.cGain) begin
               st_d.phase = PH_OFFSET;
               st_d.phCnt = 5'(ACS_OFFSET_CYC - 5'h01);
            end else if (convTick) begin
               st_d.phase = PH_SAMPLE;
               st_d.phCnt = 5'(ACS_SAMPLE_CYC - 5'h01);
            end
         end
         PH_OFFSET: begin
            if (convTick && st_q.phCnt == 5'h00) begin
               st_d.phase = PH_CORRECT;
               st_d.phCnt = 5'(ACS_CORRECT_CYC - 5'h01);
            end else if (convTick) begin
               st_d.phCnt = 5'(st_q.phCnt - 5'h01);
            end
         end
         PH_CORRECT, PH_SAMPLE: begin
            if (convTick && st_q.phCnt == 5'h00) begin
               st_d.phase = PH_CONVERT;
               st_d.phCnt = 5'(ACS_CONVERT_CYC - 5'h01);
               st_d.sar   = ACS_SAR_MSB;
            end else if (convTick) begin
               st_d.phCnt = 5'(st_q.phCnt - 5'h01);
            end
         end
         PH_CONVERT: begin
            if (setPend) begin
               st_d.result = st_q.sar;
               st_d.pend   = 1'b1;
               st_d.phase  = PH_FINISH;
            end else if (convTick) begin
               // Comparator high means input still above the trial level
               if (!compS) begin
                  st_d.sar[bitPos] = 1'b0;
               end
               if (bitPos != 3'h0) begin
                  st_d.sar[bitPos - 3'h1] = 1'b1;
               end
               st_d.phCnt = 5'(st_q.phCnt - 5'h01);
            end
         end
         PH_FINISH: begin
            st_d.busy  = 1'b0;
            st_d.phase = PH_IDLE;
         end
         default: begin
            st_d.phase = PH_IDLE;
            st_d.busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = !st_q.awHave && !st_q.bvalid;
   assign s_axi_wready  = !st_q.wHave && !st_q.bvalid;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = st_q.rdata;
   assign s_axi_rresp   = st_q.rresp;

   assign muxChannel            = st_q.busy ? st_q.cChan : st_q.chan;
   assign sarTrial              = st_q.sar;
   assign sampleHoldEnable      = st_q.phase == PH_SAMPLE;
   assign offsetMeasureEnable   = st_q.phase == PH_OFFSET;
   assign offsetCorrectEnable   = st_q.phase == PH_CORRECT;
   assign convertEnable         = st_q.phase == PH_CONVERT;
   assign autozeroEnable        = st_q.busy ? st_q.cGain : st_q.gain;
   assign errorAmpEnable        = st_q.ampEn;
   assign currentSourceEnable   = st_q.curEn;
   assign conversionInProgress  = st_q.busy;
   assign conversionPendingFlag = st_q.pend;
   assign conversionResult      = st_q.result;

   // Conversion clocks seen while busy, for the length checks
   logic [4:0] tickCnt_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tickCnt_q <= 5'h00;
      end else if (startConv) begin
         tickCnt_q <= 5'h00;
      end else if (st_q.busy && convTick && st_q.phase != PH_FINISH) begin
         tickCnt_q <= 5'(tickCnt_q + 5'h01);
      end
   end

   chk_trig_sets_busy: assert property (
      @(posedge clk) disable iff (!rst_b)
      startConv |=> st_q.busy && st_q.phase == PH_DELAY)
      else $error("trigger did not set in progress");
   chk_busy_drops_strobe: assert property (
      @(posedge clk) disable iff (!rst_b)
      st_q.busy && strobeRise |-> !startConv ##1 (st_q.phase != PH_DELAY ||
      $past(st_q.phase) == PH_DELAY))
      else $error("strobe restarted a running conversion");
   chk_gated_source: assert property (
      @(posedge clk) disable iff (!rst_b)
      startConv |-> (st_q.autoSel ? strobeRise : swStart))
      else $error("conversion started by wrong trigger");
   chk_pend_then_clear: assert property (
      @(posedge clk) disable iff (!rst_b)
      setPend |=> st_q.pend && st_q.busy ##1 !st_q.busy)
      else $error("pending and in progress out of order");
   chk_cfg_frozen: assert property (
      @(posedge clk) disable iff (!rst_b)
      st_q.busy && $past(st_q.busy) |->
      $stable(st_q.cGain) && $stable(st_q.cSpeed) && $stable(st_q.cChan))
      else $error("configuration changed during conversion");
   chk_phase_length: assert property (
      @(posedge clk) disable iff (!rst_b)
      $fell(st_q.busy) |->
      tickCnt_q == (st_q.cGain ? ACS_AZ_TOTAL : ACS_STD_TOTAL))
      else $error("conversion length wrong");
   chk_result_store: assert property (
      @(posedge clk) disable iff (!rst_b)
      setPend |=> conversionResult == $past(st_q.sar))
      else $error("result not stored from approximation");
   chk_clock_source: assert property (
      @(posedge clk) disable iff (!rst_b)
      st_q.busy && convTick |->
      (st_q.cAuto ? pwmTimerClockTick : instructionClockTick))
      else $error("conversion clock from wrong source");
   chk_cursrc_direct: assert property (
      @(posedge clk) disable iff (!rst_b)
      doWrite && wrAddr == ACS_OFF_CTRL && st_q.wStrb[0] |=>
      currentSourceEnable == $past(st_q.wData[ACS_B_CURSRC]))
      else $error("current source did not follow write");
endmodule

// ### tb/acs_front_model.sv
// Far side model: timer clock ticks, conversion strobe and comparator.
// Assumes vin and strobeReq are driven by the bench on clk.
`timescale 1ns/1ps
module acs_front_model (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [7:0] vin,
   input  wire logic [7:0] sarTrial,
   input  wire logic       strobeReq,
   output logic            pwmTimerClockTick,
   output logic            timerConversionStrobe,
   output logic            comparatorHigh
);
   // Input sits half a step above vin, so a trial equal to vin is kept
   assign comparatorHigh = (vin >= sarTrial);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwmTimerClockTick     <= 1'b0;
         timerConversionStrobe <= 1'b0;
      end else begin
         pwmTimerClockTick     <= !pwmTimerClockTick;
         timerConversionStrobe <= strobeReq;
      end
   end
endmodule

// ### tb/test_adc_conversion_sequencer.sv
// Self-checking bench of the conversion sequencer over AXI4-Lite.
// Assumes the front model answers the comparator and timer side.
`timescale 1ns/1ps
module test_adc_conversion_sequencer import acs_pkg::*; ;
   logic        clk = 1'b0, rst_b = 1'b0;
   logic [3:0]  awA, arA;
   logic [31:0] wD, rD, seed = 32'h488E8303;
   logic        awV, wV, bR, arV, rR, iTk, sReq, gated;
   logic        awRdy, wRdy, bV, arRdy, rV, pTk, strb, cmpH;
   logic        shE, omE, ocE, cvE, azE, eaE, csE, busy, pend;
   logic [1:0]  bRs, rRs;
   logic [2:0]  mux;
   logic [7:0]  vin, trial, res;
   logic [4:0]  ic = 5'h00;
   logic [15:0] tk, sF, sC, sO, sP;
   int          num_errors = 0, comparisons = 0;

   always #25 clk = ~clk;
   // Instruction clock of 1 MHz as one-cycle ticks
   always @(posedge clk) begin
      ic  <= (ic == 5'h13) ? 5'h00 : ic + 5'h01;
      iTk <= (ic == 5'h13);
   end
   // Source ticks since trigger, stamped at each phase start
   always @(posedge clk) begin
      if (!busy) tk <= 16'h0000;
      else if (gated ? pTk : iTk) tk <= tk + 16'h0001;
      if ($rose(shE) || $rose(omE)) sF <= tk;
      if ($rose(ocE)) sO <= tk;
      if ($rose(cvE)) sC <= tk;
      if ($rose(pend)) sP <= tk;
   end

   acs_sequencer u_dut (.clk, .rst_b,
      .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy),
      .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV),
      .s_axi_wready(wRdy), .s_axi_bresp(bRs), .s_axi_bvalid(bV),
      .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
      .s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rRs),
      .s_axi_rvalid(rV), .s_axi_rready(rR), .instructionClockTick(iTk),
      .pwmTimerClockTick(pTk), .timerConversionStrobe(strb),
      .comparatorHigh(cmpH), .muxChannel(mux), .sarTrial(trial),
      .sampleHoldEnable(shE), .offsetMeasureEnable(omE),
      .offsetCorrectEnable(ocE), .convertEnable(cvE),
      .autozeroEnable(azE), .errorAmpEnable(eaE),
      .currentSourceEnable(csE), .conversionInProgress(busy),
      .conversionPendingFlag(pend), .conversionResult(res));

   acs_front_model u_front (.clk, .rst_b, .vin, .sarTrial(trial),
      .strobeReq(sReq), .pwmTimerClockTick(pTk),
      .timerConversionStrobe(strb), .comparatorHigh(cmpH));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'hA3000000) : (x >> 1);
   endfunction

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awA <= a; wD <= d; awV <= 1'b1; wV <= 1'b1; bR <= 1'b1;
      do begin
         @(posedge clk);
         if (awV && awRdy) awV <= 1'b0;
         if (wV && wRdy) wV <= 1'b0;
      end while (bV !== 1'b1);
      bR <= 1'b0;
      chk(bRs, ACS_RESP_OKAY);
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      arA <= a; arV <= 1'b1; rR <= 1'b1;
      do begin
         @(posedge clk);
         if (arV && arRdy) arV <= 1'b0;
      end while (rV !== 1'b1);
      rR <= 1'b0;
      d = rD;
      chk(rRs, ACS_RESP_OKAY);
   endtask

   // Source ticks per conversion tick
   function automatic logic [15:0] perTick(input logic g,
         input logic [31:0] p, input logic [1:0] s);
      logic [15:0] t;
      t = !g ? 16'h0001 : p[ACS_B_FAST_CLOCK_MODE] ? 16'(ACS_TDIV_FAST) :
          p[ACS_B_CLOCK_SOURCE_SELECT] ? 16'(ACS_TDIV_SRC) : 16'(ACS_TDIV_BASE);
      if (g && p[ACS_B_FS]) t = t << 1;
      return t << s;
   endfunction

   task automatic conv(input logic g, input logic [31:0] p,
         input logic [1:0] s, input logic [31:0] r);
      logic z;
      logic [2:0] ch;
      logic [15:0] k;
      logic [31:0] d;
      int n;
      z = r[8]; ch = z ? 3'h1 : r[11:9]; k = perTick(g, p, s);
      vin <= r[23:16]; gated <= g;
      wr(ACS_OFF_PRESC, p);
      wr(ACS_OFF_CTRL, {21'h0, ch, 3'b000, z, s, g, !g});
      if (g) begin
         // Start bit has no effect once gated mode is set
         wr(ACS_OFF_CTRL, {21'h0, ch, 3'b000, z, s, g, 1'b1});
         repeat (4) @(posedge clk);
         chk(busy, 1'b0);
         sReq <= 1'b1;
      end
      n = 0;
      while (busy !== 1'b1 && n < 40) begin @(posedge clk); n++; end
      chk(busy, 1'b1);
      sReq <= 1'b0;
      repeat (4) @(posedge clk);
      sReq <= g; // Second strobe edge while running
      wr(ACS_OFF_CTRL, {21'h0, ~ch, 3'b000, !z, ~s, g, 1'b0});
      chk(mux, ch);
      chk(azE, z);
      n = 0;
      while (pend !== 1'b1 && n < 20000) begin @(posedge clk); n++; end
      chk(busy, 1'b1);
      @(posedge clk);
      chk(busy, 1'b0);
      chk(res, r[23:16]);
      rd(ACS_OFF_STATUS, d);
      chk(d[15:0], {r[23:16], 8'h02});
      rd(ACS_OFF_RESULT, d);
      chk(d, {24'h0, r[23:16]});
      chk(sF, k);
      if (z) chk(sO, 7 * k);
      chk(sC, z ? 12 * k : 5 * k);
      chk(sP, z ? 21 * k : 14 * k);
      wr(ACS_OFF_STATUS, 32'h2);
      chk(pend, 1'b0);
      sReq <= 1'b0;
   endtask

   task automatic test_done;
      $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      logic [31:0] r, d;
      {awA, arA, wD, awV, wV, bR, arV, rR, sReq, gated} <= '0;
      vin <= 8'h00;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk({awRdy, wRdy, arRdy, busy, pend, res}, 13'h1C00);
      rd(ACS_OFF_CTRL, d);
      chk(d, 32'h0);
      rd(ACS_OFF_PRESC, d);
      chk(d, 32'h0);
      // Every speed, with full-scale and zero inputs as corners
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         r = seed;
         if (i < 2) r[23:16] = (i == 0) ? 8'hFF : 8'h00;
         conv(1'b0, 32'h0, 2'(i), r);
      end
      // Fast mode, source select, then neither
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         r = seed;
         conv(1'b1, {24'h0, r[7:2], i == 1, i == 0},
              {1'b0, r[12] || i == 2}, r);
      end
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(ACS_OFF_CTRL, {21'h0, seed[2:0], 1'b0, 2'(i), 5'h00});
         chk(eaE, i[0]);
         chk(csE, i[1]);
         chk(mux, seed[2:0]);
         rd(ACS_OFF_CTRL, d);
         chk(d[10:0], {seed[2:0], 1'b0, 2'(i), 5'h00});
      end
      test_done;
   end

   // Longest expected run is near 6400 cycles
   initial begin
      repeat (80000) @(posedge clk);
      num_errors++;
      test_done;
   end
endmodule
